// ==== include/gher_pkg.sv ====
// ---------------------------------------------------------------
// Shared constants for guest/host exception routing
// ---------------------------------------------------------------
package gher_pkg;
    // Data and partition widths
    localparam int XLEN = 32;
    localparam int PID_W = 8;
    localparam int REG_ADDR_W = 7;
    // Register indices; byte address is four times the index
    localparam int IDX_HIGH = 0;
    localparam int IDX_HSW = 1;
    localparam int IDX_GSW = 2;
    localparam int IDX_HF_PC = 3;
    localparam int IDX_HI_PC = 6;
    localparam int IDX_GF_PC = 9;
    localparam int IDX_GI_PC = 12;
    localparam int IDX_F_HIGH = 15;
    localparam int IDX_I_HIGH = 16;
    localparam int NREG = 17;
    // Offsets inside one context set
    localparam int CTX_ST = 1;
    localparam int CTX_CA = 2;
    // High status word fields
    localparam int HIGH_GUEST_BIT = 31;
    localparam int HIGH_PID_LSB = 0;
    // Status word mask bits
    localparam int ST_INTR_MASK_BIT = 5;
    localparam int ST_FATAL_MASK_BIT = 7;
    // Reset values
    localparam logic [XLEN-1:0] HIGH_RST = 32'h0000_0000;
    localparam logic [XLEN-1:0] STATUS_RST = 32'h0000_0000;
    localparam logic [XLEN-1:0] CTX_RST = 32'h0000_0000;
    // Cause codes for background requests
    localparam logic [XLEN-1:0] CAUSE_BG_FATAL = 32'h0000_00f1;
    localparam logic [XLEN-1:0] CAUSE_BG_INTR = 32'h0000_00f0;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SYNC = 3'b010,
        ST_COMMIT = 3'b100
    } gher_state_t;
endpackage

// ==== src/gher_core.sv ====
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module gher_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Exception source
    input wire logic exc_valid,
    input wire logic exc_fatal,
    input wire logic exc_host_handled,
    input wire logic hypervisor_trap_instruction,
    input wire logic [gher_pkg::XLEN-1:0] exc_cause,
    input wire logic [gher_pkg::XLEN-1:0] exc_pc,
    // Return instruction
    input wire logic ret_valid,
    input wire logic ret_fatal,
    // Guest interrupts
    input wire logic guest_fatal_request,
    input wire logic [gher_pkg::PID_W-1:0] guest_fatal_pid,
    input wire logic [gher_pkg::XLEN-1:0] guest_fatal_code,
    input wire logic guest_intr_request,
    input wire logic [gher_pkg::PID_W-1:0] guest_intr_pid,
    input wire logic [gher_pkg::XLEN-1:0] guest_intr_code,
    input wire logic [gher_pkg::XLEN-1:0] intr_pc,
    // Background interrupts
    input wire logic background_fatal_request,
    input wire logic [gher_pkg::PID_W-1:0] background_fatal_pid,
    input wire logic background_intr_request,
    input wire logic [gher_pkg::PID_W-1:0] background_intr_pid,
    // Memory synchronisation
    input wire logic mem_idle,
    input wire logic err_check_done,
    output logic memory_sync_barrier,
    // Register port
    input wire logic [gher_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic [gher_pkg::XLEN-1:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [gher_pkg::XLEN-1:0] reg_rdata,
    // Acknowledge outputs
    output logic busy,
    output logic ack_valid,
    output logic ack_to_host,
    output logic ack_fatal,
    output logic ack_guest_fatal,
    output logic ack_guest_intr,
    output logic ack_background,
    output logic ret_done,
    output logic [gher_pkg::XLEN-1:0] ret_pc,
    // Mode state
    output logic high_status_guest_flag,
    output logic [gher_pkg::PID_W-1:0] high_status_partition_number
);
    import gher_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------

    // All state of the routing unit
    typedef struct packed {
        gher_state_t st;
        logic [NREG-1:0][XLEN-1:0] regs;
        logic p_ret;
        logic p_host;
        logic p_fatal;
        logic p_tr;
        logic [2:0] p_kind;
        logic [XLEN-1:0] p_cause;
        logic [XLEN-1:0] p_pc;
        logic [XLEN-1:0] rdata;
        logic busy;
        logic ack;
        logic ack_host;
        logic ack_fat;
        logic [2:0] ack_kind;
        logic ret_done;
        logic [XLEN-1:0] ret_pc;
    } gher_core_st_t;

    gher_core_st_t s_r;
    gher_core_st_t s_nxt;
    logic sync_done;
    logic gm;
    logic [PID_W-1:0] pid;
    logic take_gf;
    logic take_gi;
    logic take_bf;
    logic take_bi;
    logic take_exc;
    logic take_ret;
    logic idle_free;
    int base;
    int idx;

    // Current mode and partition
    assign gm = s_r.regs[IDX_HIGH][HIGH_GUEST_BIT];
    assign pid = s_r.regs[IDX_HIGH][HIGH_PID_LSB +: PID_W];
    // Block a request in the cycle its acknowledge is shown
    assign idle_free = (s_r.st == ST_IDLE) && !s_r.ack && !s_r.ret_done;
    assign idx = int'(reg_addr[REG_ADDR_W-1:2]);

    // ---------------------------------------------------------------
    // Acceptance
    // ---------------------------------------------------------------

    // Priority: return, exception, guest fatal, background fatal, guest intr, background intr
    always_comb begin
        take_ret = idle_free && ret_valid;
        take_exc = idle_free && !ret_valid && exc_valid;
        take_gf = idle_free && !ret_valid && !exc_valid && guest_fatal_request && gm
            && (guest_fatal_pid == pid) && !s_r.regs[IDX_GSW][ST_FATAL_MASK_BIT];
        take_bf = idle_free && !ret_valid && !exc_valid && !take_gf && background_fatal_request && gm
            && (background_fatal_pid != pid) && !s_r.regs[IDX_HSW][ST_INTR_MASK_BIT];
        take_gi = idle_free && !ret_valid && !exc_valid && !take_gf && !take_bf && guest_intr_request
            && gm && (guest_intr_pid == pid) && !s_r.regs[IDX_GSW][ST_INTR_MASK_BIT];
        // background only in guest mode with mismatch
        take_bi = idle_free && !ret_valid && !exc_valid && !take_gf && !take_bf && !take_gi
            && background_intr_request && gm && (background_intr_pid != pid)
            && !s_r.regs[IDX_HSW][ST_INTR_MASK_BIT];
    end

    // ---------------------------------------------------------------
    // Sequencer and context update
    // ---------------------------------------------------------------

    // Next state of the whole unit
    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        s_nxt.ack_kind = 3'h0;
        s_nxt.ret_done = 1'b0;
        base = s_r.p_fatal ? (s_r.p_host ? IDX_HF_PC : IDX_GF_PC) : (s_r.p_host ? IDX_HI_PC : IDX_GI_PC);
        // Software write, overridden by a commit below
        if (reg_we && idx < NREG) begin
            s_nxt.regs[idx] = reg_wdata;
        end
        // Read data one cycle later, zero when unmapped
        s_nxt.rdata = (reg_re && idx < NREG) ? s_r.regs[idx] : '0;
        case (s_r.st)
            ST_IDLE: begin
                if (take_ret) begin
                    // Return uses host registers only from host mode
                    s_nxt.p_ret = 1'b1;
                    s_nxt.p_host = !gm;
                    s_nxt.p_fatal = ret_fatal;
                    s_nxt.p_kind = 3'b000;
                    s_nxt.p_tr = !gm && (ret_fatal ? s_r.regs[IDX_F_HIGH][HIGH_GUEST_BIT]
                        : s_r.regs[IDX_I_HIGH][HIGH_GUEST_BIT]);
                end else if (take_exc) begin
                    s_nxt.p_ret = 1'b0;
                    s_nxt.p_host = !gm || exc_host_handled || hypervisor_trap_instruction;
                    s_nxt.p_fatal = exc_fatal;
                    s_nxt.p_kind = 3'b000;
                    s_nxt.p_cause = exc_cause;
                    s_nxt.p_pc = exc_pc;
                    s_nxt.p_tr = gm && (exc_host_handled || hypervisor_trap_instruction);
                end else if (take_gf || take_gi) begin
                    // guest interrupt handled inside its partition
                    s_nxt.p_ret = 1'b0;
                    s_nxt.p_host = 1'b0;
                    s_nxt.p_fatal = take_gf;
                    s_nxt.p_kind = take_gf ? 3'b001 : 3'b010;
                    s_nxt.p_cause = take_gf ? guest_fatal_code : guest_intr_code;
                    s_nxt.p_pc = intr_pc;
                    s_nxt.p_tr = 1'b0;
                end else if (take_bf || take_bi) begin
                    // background is a host interrupt-level entry
                    s_nxt.p_ret = 1'b0;
                    s_nxt.p_host = 1'b1;
                    s_nxt.p_fatal = 1'b0;
                    s_nxt.p_kind = 3'b100;
                    s_nxt.p_cause = take_bf ? CAUSE_BG_FATAL : CAUSE_BG_INTR;
                    s_nxt.p_pc = intr_pc;
                    s_nxt.p_tr = 1'b1;
                end
                if (take_ret || take_exc || take_gf || take_gi || take_bf || take_bi) begin
                    if (s_nxt.p_tr) begin
                        s_nxt.st = ST_SYNC;
                    end else begin
                        s_nxt.st = ST_COMMIT;
                    end
                end
            end
            ST_SYNC: begin
                // Wait for the barrier to finish
                if (sync_done) begin
                    s_nxt.st = ST_COMMIT;
                end
            end
            ST_COMMIT: begin
                s_nxt.st = ST_IDLE;
                if (s_r.p_ret && s_r.p_host) begin
                    // restore host status and mode state
                    s_nxt.regs[IDX_HSW] = s_r.regs[base + CTX_ST];
                    s_nxt.regs[IDX_HIGH] = s_r.p_fatal ? s_r.regs[IDX_F_HIGH] : s_r.regs[IDX_I_HIGH];
                    s_nxt.ret_pc = s_r.regs[base];
                    s_nxt.ret_done = 1'b1;
                end else if (s_r.p_ret) begin
                    // Guest return restores the guest status word
                    s_nxt.regs[IDX_GSW] = s_r.regs[base + CTX_ST];
                    s_nxt.ret_pc = s_r.regs[base];
                    s_nxt.ret_done = 1'b1;
                end else if (s_r.p_host) begin
                    // host context set receives the save
                    s_nxt.regs[base] = s_r.p_pc;
                    s_nxt.regs[base + CTX_ST] = s_r.regs[IDX_HSW];
                    s_nxt.regs[base + CTX_CA] = s_r.p_cause;
                    // save guest flag and partition by level
                    if (s_r.p_fatal) begin
                        s_nxt.regs[IDX_F_HIGH] = s_r.regs[IDX_HIGH];
                    end else begin
                        s_nxt.regs[IDX_I_HIGH] = s_r.regs[IDX_HIGH];
                    end
                    // mask further entries in host status
                    s_nxt.regs[IDX_HSW][ST_INTR_MASK_BIT] = 1'b1;
                    if (s_r.p_fatal) begin
                        s_nxt.regs[IDX_HSW][ST_FATAL_MASK_BIT] = 1'b1;
                    end
                    // an exception only ever clears the guest flag
                    s_nxt.regs[IDX_HIGH][HIGH_GUEST_BIT] = 1'b0;
                end else begin
                    // guest context set, no high status save
                    s_nxt.regs[base] = s_r.p_pc;
                    s_nxt.regs[base + CTX_ST] = s_r.regs[IDX_GSW];
                    s_nxt.regs[base + CTX_CA] = s_r.p_cause;
                    s_nxt.regs[IDX_GSW][ST_INTR_MASK_BIT] = 1'b1;
                    if (s_r.p_fatal) begin
                        s_nxt.regs[IDX_GSW][ST_FATAL_MASK_BIT] = 1'b1;
                    end
                end
                if (!s_r.p_ret) begin
                    s_nxt.ack = 1'b1;
                    s_nxt.ack_host = s_r.p_host;
                    s_nxt.ack_fat = s_r.p_fatal;
                    // background ack never clears the guest source
                    s_nxt.ack_kind = s_r.p_kind;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
        s_nxt.busy = (s_nxt.st != ST_IDLE);
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.regs <= {NREG{CTX_RST}};
            s_r.regs[IDX_HIGH] <= HIGH_RST;
            s_r.regs[IDX_HSW] <= STATUS_RST;
            s_r.regs[IDX_GSW] <= STATUS_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Barrier and outputs
    // ---------------------------------------------------------------

    // Barrier sequencer started on entry to the sync state
    gher_sync u_sync (
        .clk(clk),
        .rst(rst),
        .start((s_r.st == ST_IDLE) && (s_nxt.st == ST_SYNC)),
        .done(sync_done),
        .mem_idle(mem_idle),
        .err_check_done(err_check_done),
        .sync_req(memory_sync_barrier)
    );

    assign reg_rdata = s_r.rdata;
    assign busy = s_r.busy;
    assign ack_valid = s_r.ack;
    assign ack_to_host = s_r.ack_host;
    assign ack_fatal = s_r.ack_fat;
    assign ack_guest_fatal = s_r.ack_kind[0];
    assign ack_guest_intr = s_r.ack_kind[1];
    assign ack_background = s_r.ack_kind[2];
    assign ret_done = s_r.ret_done;
    assign ret_pc = s_r.ret_pc;
    assign high_status_guest_flag = gm;
    assign high_status_partition_number = pid;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------

    logic commit_exc;
    assign commit_exc = (s_r.st == ST_COMMIT) && !s_r.p_ret;

    a_no_guest_entry: assert property (@(posedge clk) disable iff (rst)
        commit_exc && !gm |=> !gm) else $error("exception entered guest mode");
    a_guest_stays: assert property (@(posedge clk) disable iff (rst)
        commit_exc && !s_r.p_host && gm |=> gm && $stable(pid)) else $error("guest handling left partition");
    a_trap_host: assert property (@(posedge clk) disable iff (rst)
        take_exc && hypervisor_trap_instruction |=> s_r.p_host) else $error("trap not routed to host");
    a_high_saved: assert property (@(posedge clk) disable iff (rst)
        commit_exc && s_r.p_host && !s_r.p_fatal |=> s_r.regs[IDX_I_HIGH] == $past(s_r.regs[IDX_HIGH]))
        else $error("high status not saved");
    a_ret_restore: assert property (@(posedge clk) disable iff (rst)
        (s_r.st == ST_COMMIT) && s_r.p_ret && s_r.p_host && s_r.p_fatal
        |=> s_r.regs[IDX_HIGH] == $past(s_r.regs[IDX_F_HIGH])) else $error("high status not restored");
    a_host_ctx: assert property (@(posedge clk) disable iff (rst)
        commit_exc && s_r.p_host && s_r.p_fatal |=> s_r.regs[IDX_HF_PC] == $past(s_r.p_pc))
        else $error("host pc not saved");
    a_guest_untouched: assert property (@(posedge clk) disable iff (rst)
        commit_exc && s_r.p_host && !reg_we |=> $stable(s_r.regs[IDX_GI_PC]) && $stable(s_r.regs[IDX_GF_PC]))
        else $error("guest context written");
    a_host_mask: assert property (@(posedge clk) disable iff (rst)
        commit_exc && s_r.p_host |=> s_r.regs[IDX_HSW][ST_INTR_MASK_BIT]) else $error("host mask not set");
    a_sync_before: assert property (@(posedge clk) disable iff (rst)
        (s_r.st == ST_COMMIT) && s_r.p_tr |-> $past(sync_done)) else $error("transition without barrier");
    a_gint_match: assert property (@(posedge clk) disable iff (rst)
        ack_guest_fatal |-> $past(s_r.p_kind[0]) && gm) else $error("guest fatal ack outside guest");
    a_bg_host: assert property (@(posedge clk) disable iff (rst)
        (take_bi || take_bf) |-> gm ##1 s_r.p_host && !s_r.p_fatal) else $error("background mishandled");
    a_bg_level: assert property (@(posedge clk) disable iff (rst)
        commit_exc && s_r.p_kind[2] |=> !gm && ack_background && !ack_fatal) else $error("background not host");

    c_guest_to_host: cover property (@(posedge clk) disable iff (rst) commit_exc && s_r.p_tr);
    c_guest_local: cover property (@(posedge clk) disable iff (rst) commit_exc && !s_r.p_host);
    c_background: cover property (@(posedge clk) disable iff (rst) ack_background);
    c_return_guest: cover property (@(posedge clk) disable iff (rst) ret_done && gm);
endmodule

// ==== src/gher_sync.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Memory barrier sequencer for mode transitions
// ---------------------------------------------------------------
module gher_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic start,
    output logic done,
    // Memory side
    input wire logic mem_idle,
    input wire logic err_check_done,
    output logic sync_req
);
    import gher_pkg::*;

    // All state of the sequencer
    typedef struct packed {
        logic req;
        logic done;
    } gher_sync_st_t;

    gher_sync_st_t s_r;
    gher_sync_st_t s_nxt;

    // Hold the barrier until loads, stores and error checks end
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (start) begin
            s_nxt.req = 1'b1;
        end else if (s_r.req && mem_idle && err_check_done) begin
            s_nxt.req = 1'b0;
            s_nxt.done = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sync_req = s_r.req;
    assign done = s_r.done;
endmodule

// ==== verif/gher_intc_model.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Interrupt controller model: guest and background requests
// ---------------------------------------------------------------
module gher_intc_model (
    // Clock and reset
    input logic clk,
    input logic rst,
    // Bench commands
    input logic raise_fatal,
    input logic raise_intr,
    input logic [gher_pkg::PID_W-1:0] raise_pid,
    input logic bg_enable,
    // Core side
    input logic [gher_pkg::PID_W-1:0] high_status_partition_number,
    input logic ack_guest_fatal,
    input logic ack_guest_intr,
    input logic ack_background,
    output logic guest_fatal_request,
    output logic [gher_pkg::PID_W-1:0] guest_fatal_pid,
    output logic [gher_pkg::XLEN-1:0] guest_fatal_code,
    output logic guest_intr_request,
    output logic [gher_pkg::PID_W-1:0] guest_intr_pid,
    output logic [gher_pkg::XLEN-1:0] guest_intr_code,
    output logic background_fatal_request,
    output logic [gher_pkg::PID_W-1:0] background_fatal_pid,
    output logic background_intr_request,
    output logic [gher_pkg::PID_W-1:0] background_intr_pid
);
    import gher_pkg::*;
    // Pending guest sources, their partitions and background copies
    logic gf_r, gi_r, bgf_r, bgi_r;
    logic [PID_W-1:0] gf_pid_r, gi_pid_r;
    // Outputs follow the pending state
    assign guest_fatal_request = gf_r;
    assign guest_fatal_pid = gf_pid_r;
    assign guest_fatal_code = 32'h0000_0011;
    assign guest_intr_request = gi_r;
    assign guest_intr_pid = gi_pid_r;
    assign guest_intr_code = 32'h0000_0022;
    assign background_fatal_request = bgf_r;
    assign background_fatal_pid = gf_pid_r;
    assign background_intr_request = bgi_r;
    assign background_intr_pid = gi_pid_r;
    // mismatch raises background; its acknowledge keeps source
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gf_r <= 1'b0;
            gi_r <= 1'b0;
            bgf_r <= 1'b0;
            bgi_r <= 1'b0;
            gf_pid_r <= 8'h00;
            gi_pid_r <= 8'h00;
        end else begin
            if (raise_fatal) begin
                gf_r <= 1'b1;
                gf_pid_r <= raise_pid;
                bgf_r <= bg_enable && (raise_pid != high_status_partition_number);
            end else if (ack_guest_fatal) begin
                gf_r <= 1'b0;
                bgf_r <= 1'b0;
            end else if (ack_background && bgf_r) begin
                bgf_r <= 1'b0;
            end
            if (raise_intr) begin
                gi_r <= 1'b1;
                gi_pid_r <= raise_pid;
                bgi_r <= bg_enable && (raise_pid != high_status_partition_number);
            end else if (ack_guest_intr) begin
                gi_r <= 1'b0;
                bgi_r <= 1'b0;
            end else if (ack_background && !bgf_r) begin
                bgi_r <= 1'b0;
            end
        end
    end
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Bench: register port, exceptions, returns, guest interrupts
// ---------------------------------------------------------------
module tb_top;
    import gher_pkg::*;
    // Stimulus and observed signals
    logic clk = 1'b0, rst = 1'b1, mem_idle = 1'b1, err_check_done = 1'b1, reg_we = 1'b0, reg_re = 1'b0;
    logic exc_valid = 1'b0, exc_fatal = 1'b0, exc_host_handled = 1'b0, hypervisor_trap_instruction = 1'b0;
    logic ret_valid = 1'b0, ret_fatal = 1'b0, raise_fatal = 1'b0, raise_intr = 1'b0, bg_enable = 1'b0;
    logic [PID_W-1:0] raise_pid = 8'h00, guest_fatal_pid, guest_intr_pid, background_fatal_pid, background_intr_pid;
    logic [REG_ADDR_W-1:0] reg_addr = 7'h00;
    logic [XLEN-1:0] exc_cause = 32'h0, exc_pc = 32'h0, reg_wdata = 32'h0;
    logic [XLEN-1:0] reg_rdata, ret_pc, guest_fatal_code, guest_intr_code;
    logic guest_fatal_request, guest_intr_request, background_fatal_request, background_intr_request;
    logic memory_sync_barrier, busy, ack_valid, ack_to_host, ack_fatal, ack_guest_fatal, ack_guest_intr;
    logic ack_background, ret_done, high_status_guest_flag;
    logic [PID_W-1:0] high_status_partition_number;
    int err_total = 0, compares = 0;
    // Design and interrupt controller
    gher_core i_gher_core (.clk, .rst, .exc_valid, .exc_fatal, .exc_host_handled, .hypervisor_trap_instruction,
        .exc_cause, .exc_pc, .ret_valid, .ret_fatal, .guest_fatal_request, .guest_fatal_pid, .guest_fatal_code,
        .guest_intr_request, .guest_intr_pid, .guest_intr_code, .intr_pc(32'h0000_0400),
        .background_fatal_request, .background_fatal_pid, .background_intr_request, .background_intr_pid,
        .mem_idle, .err_check_done, .memory_sync_barrier, .reg_addr, .reg_wdata, .reg_we, .reg_re,
        .reg_rdata, .busy, .ack_valid, .ack_to_host, .ack_fatal, .ack_guest_fatal, .ack_guest_intr,
        .ack_background, .ret_done, .ret_pc, .high_status_guest_flag, .high_status_partition_number);
    gher_intc_model i_gher_intc_model (.clk, .rst, .raise_fatal, .raise_intr, .raise_pid, .bg_enable,
        .high_status_partition_number, .ack_guest_fatal, .ack_guest_intr, .ack_background,
        .guest_fatal_request, .guest_fatal_pid, .guest_fatal_code, .guest_intr_request, .guest_intr_pid,
        .guest_intr_code, .background_fatal_request, .background_fatal_pid, .background_intr_request,
        .background_intr_pid);
    // Clock of 10 ns
    initial begin
        forever #5 clk = ~clk;
    end
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [XLEN-1:0] seen, input logic [XLEN-1:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("compares %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr(input int idx, input logic [XLEN-1:0] d);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= REG_ADDR_W'(idx * 4);
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask
    task automatic rd(input int idx, input logic [XLEN-1:0] exp);
        @(posedge clk);
        reg_re <= 1'b1;
        reg_addr <= REG_ADDR_W'(idx * 4);
        @(posedge clk);
        reg_re <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    // Waits for an entry or return; slow memory checks the barrier
    task automatic wait_evt(input bit slow);
        int n;
        n = 0;
        if (slow) begin
            repeat (4) @(posedge clk);
            #1;
            chk({memory_sync_barrier, busy}, 2'b11);
            chk(ack_valid | ret_done, 0);
            {mem_idle, err_check_done} <= 2'b11;
        end
        while (ack_valid !== 1'b1 && ret_done !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 60) begin
                err_total++;
                results();
            end
        end
    endtask
    task automatic exc(input bit f, input bit hh, input bit trap, input logic [XLEN-1:0] pc,
                       input logic [XLEN-1:0] cause, input bit slow);
        @(posedge clk);
        exc_valid <= 1'b1;
        exc_fatal <= f;
        exc_host_handled <= hh;
        hypervisor_trap_instruction <= trap;
        exc_pc <= pc;
        exc_cause <= cause;
        mem_idle <= !slow;
        wait_evt(slow);
        @(posedge clk);
        exc_valid <= 1'b0;
    endtask
    task automatic ret(input bit f, input bit slow);
        @(posedge clk);
        ret_valid <= 1'b1;
        ret_fatal <= f;
        err_check_done <= !slow;
        wait_evt(slow);
        @(posedge clk);
        ret_valid <= 1'b0;
    endtask
    task automatic raise(input bit f, input logic [PID_W-1:0] pid, input bit bg);
        @(posedge clk);
        raise_fatal <= f;
        raise_intr <= !f;
        raise_pid <= pid;
        bg_enable <= bg;
        @(posedge clk);
        raise_fatal <= 1'b0;
        raise_intr <= 1'b0;
    endtask
    task automatic no_ack(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            chk(ack_valid, 0);
        end
    endtask
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i <= NREG; i++) begin
            rd(i, 32'h0);
        end
        wr(NREG, 32'hffff_ffff);
        rd(NREG, 32'h0);
        $display("test reset done");
        exc(1'b1, 1'b1, 1'b0, 32'h0000_0100, 32'h0000_0044, 1'b0);
        chk(ack_to_host, 1);
        chk(high_status_guest_flag, 0);
        rd(IDX_HF_PC + CTX_CA, 32'h0000_0044);
        rd(IDX_F_HIGH, 32'h0);
        $display("test host entry done");
        wr(IDX_I_HIGH, 32'h8000_0003);
        wr(IDX_HI_PC, 32'h0000_0180);
        ret(1'b0, 1'b1);
        chk(ret_pc, 32'h0000_0180);
        chk({high_status_guest_flag, high_status_partition_number}, 9'h103);
        $display("test enter guest done");
        exc(1'b0, 1'b0, 1'b0, 32'h0000_0300, 32'h0000_0055, 1'b0);
        chk({ack_to_host, high_status_guest_flag}, 2'b01);
        rd(IDX_GI_PC, 32'h0000_0300);
        rd(IDX_GI_PC + CTX_CA, 32'h0000_0055);
        rd(IDX_I_HIGH, 32'h8000_0003);
        wr(IDX_GSW, 32'h0);
        $display("test guest entry done");
        raise(1'b0, 8'h05, 1'b0);
        no_ack(10);
        raise(1'b0, 8'h05, 1'b1);
        wait_evt(1'b0);
        chk({ack_background, ack_to_host, ack_fatal, ack_guest_intr}, 4'b1100);
        rd(IDX_HI_PC, 32'h0000_0400);
        rd(IDX_HI_PC + CTX_CA, CAUSE_BG_INTR);
        rd(IDX_I_HIGH, 32'h8000_0003);
        chk({high_status_guest_flag, guest_intr_request}, 2'b01);
        $display("test background done");
        raise(1'b1, 8'h05, 1'b1);
        no_ack(10);
        wr(IDX_GSW, 32'h0000_00a0);
        wr(IDX_I_HIGH, 32'h8000_0005);
        ret(1'b0, 1'b0);
        no_ack(10);
        wr(IDX_GSW, 32'h0);
        wait_evt(1'b0);
        chk({ack_guest_fatal, ack_background, ack_to_host}, 3'b100);
        rd(IDX_GF_PC + CTX_CA, 32'h0000_0011);
        $display("test partition match done");
        wr(IDX_HSW, 32'h0000_0001);
        exc(1'b1, 1'b0, 1'b1, 32'h0000_0200, 32'h0000_0033, 1'b1);
        chk({ack_to_host, high_status_guest_flag}, 2'b10);
        rd(IDX_F_HIGH, 32'h8000_0005);
        rd(IDX_HF_PC, 32'h0000_0200);
        rd(IDX_HF_PC + CTX_ST, 32'h0000_0001);
        rd(IDX_HSW, 32'h0000_00a1);
        rd(IDX_GF_PC, 32'h0000_0400);
        ret(1'b1, 1'b1);
        chk(ret_pc, 32'h0000_0200);
        chk({high_status_guest_flag, high_status_partition_number}, 9'h105);
        rd(IDX_HSW, 32'h0000_0001);
        $display("test trap done");
        results();
    end
endmodule
